//--- include/occr_defs.svh
// constants of the oscillator control register block
`ifndef OCCR_DEFS_SVH
`define OCCR_DEFS_SVH
`define OCCR_ADDR_W        2
`define OCCR_ADDR_OSC_CTRL 2'h0
`define OCCR_ADDR_CLK_DIV  2'h1
`define OCCR_ADDR_RC_TUNE  2'h2
`define OCCR_CUR_HI        14
`define OCCR_CUR_LO        12
`define OCCR_NXT_HI        10
`define OCCR_NXT_LO        8
`define OCCR_LOCK_BIT      7
`define OCCR_PINLOCK_BIT   6
`define OCCR_PLL_BIT       5
`define OCCR_FAIL_BIT      3
`define OCCR_SOSC_BIT      1
`define OCCR_SWREQ_BIT     0
`define OCCR_ROI_BIT       15
`define OCCR_DOZE_HI       14
`define OCCR_DOZE_LO       12
`define OCCR_RATIO_REDUCTION_ENABLE_BIT     11
`define OCCR_POST_HI       10
`define OCCR_POST_LO       8
`define OCCR_TUN_HI        5
`define OCCR_TUN_LO        0
`define OCCR_DOZE_RST      3'h3
`define OCCR_POST_RST      3'h0
`define OCCR_TUN_RST       6'h00
`define OCCR_UNLOCK_KEY1   16'h0057
`define OCCR_UNLOCK_KEY2   16'h00AA
`define OCCR_SW_CYCLES     4'h8
`define OCCR_ZERO16        16'h0000
`endif

//--- include/occr_pkg.sv
// types of the oscillator control register block
package occr_pkg;
  typedef enum logic [2:0] {
    OCCR_SRC_FRC, OCCR_SRC_FRC_PLL, OCCR_SRC_PRI, OCCR_SRC_PRI_PLL,
    OCCR_SRC_SEC, OCCR_SRC_LOW_POWER_RC, OCCR_SRC_FRC_DIV16, OCCR_SRC_FRC_DIVN
  } occr_src_t;
  typedef enum logic [1:0] {
    OCCR_UNL_IDLE, OCCR_UNL_KEY1, OCCR_UNL_OPEN
  } occr_unl_t;
endpackage : occr_pkg

//--- hw/occr_sync2.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module occr_sync2 (
  input  wire logic clk,
  input  wire logic d,
  output logic      q
);
  logic meta_ff;
  always_ff @(posedge clk) begin
    meta_ff <= d;
    q       <= meta_ff;
  end
endmodule : occr_sync2
`default_nettype wire

//--- hw/occr_top.sv
// oscillator control, divisor and tuning registers with doze divider
// Function
// [R1] registers reset only on power-on reset, other resets leave them
// [R2] read-only current source field at bits 14-12, eight source codes
// [R3] writable next source field at bits 10-8, same encoding
// [R4] current and next source load from config bits at power-on
// [R5] mode 01: lock bit 7 set blocks switching, clear allows it
// [R6] pin-select lock bit 6 refuses pin-select register writes
// [R7] pll lock flag bit 5 reads lock or expired start-up timer; code also requires pll enabled, else reads 0
// [R8] clock fail bit 3 set by monitor, cleared by software only
// [R9] bit 1 enables secondary oscillator, reset zero
// [R10] switch request bit 0 set by software, cleared on completion
// [R11] control register writes ignored without prior unlock sequence
// [R12] recover-on-interrupt clears doze enable on any interrupt
// [R13] doze field divides instruction clock by two to field power
// [R14] doze enable gives ratio from field, else forced 1:1
// [R15] postscaler divides 1..64 for 000..110, 256 for 111
// [R16] tuning field is signed 6-bit trim, reset zero
// [R17] unimplemented bits read zero, writes ignored
// [R18] instruction clock is system clock divided by two
// [R19] mode 1x no switching no monitor, 01 switching, 00 both
// [R20] switch completes by copying next to current, then clearing request; code does both in the same cycle
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "occr_defs.svh"
module occr_top (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  por_n,
  input  wire logic [2:0]            init_source_cfg,
  input  wire logic [1:0]            switch_monitor_config,
  input  wire logic                  pll_locked,
  input  wire logic                  pll_timer_done,
  input  wire logic                  pll_enabled,
  input  wire logic                  fail_detect,
  input  wire logic                  irq_event,
  input  wire logic                  pin_select_wr,
  input  wire logic [`OCCR_ADDR_W-1:0] addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic [15:0]                rdata,
  output occr_pkg::occr_src_t        current_source_sel,
  output logic                       secondary_osc_enable,
  output logic                       pin_select_wr_ok,
  output logic                       fail_safe_monitor,
  output logic                       cpu_clk_en,
  output logic                       periph_clk_en,
  output logic [2:0]                 rc_postscaler_sel,
  output logic [7:0]                 rc_post_ratio_m1,
  output logic [5:0]                 rc_trim_field
);
  import occr_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic pll_locked_s, pll_timer_s, pll_en_s, fail_s, irq_s;
  occr_sync2 u_sync_lock (.clk(clk), .d(pll_locked),     .q(pll_locked_s));
  occr_sync2 u_sync_tmr  (.clk(clk), .d(pll_timer_done), .q(pll_timer_s));
  occr_sync2 u_sync_en   (.clk(clk), .d(pll_enabled),    .q(pll_en_s));
  occr_sync2 u_sync_fail (.clk(clk), .d(fail_detect),    .q(fail_s));
  occr_sync2 u_sync_irq  (.clk(clk), .d(irq_event),      .q(irq_s));

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  occr_src_t cur_ff, nxt_src_ff;
  logic      lock_ff, pinlock_ff, fail_ff, sosc_ff, swreq_ff;
  logic      roi_ff, ratio_reduction_enable_ff;
  logic [2:0] doze_ff, post_ff;
  logic [5:0] tun_ff;
  occr_unl_t unl_ff;
  logic [3:0] sw_cnt_ff;
  logic       irq_d_ff;

  logic switch_allowed, sel_ctrl, sel_div, sel_tun, ctrl_wr, irq_rise;
  assign switch_allowed = !switch_monitor_config[1] && !lock_ff;   // [R19] [R5]
  assign sel_ctrl = (addr == `OCCR_ADDR_OSC_CTRL);
  assign sel_div  = (addr == `OCCR_ADDR_CLK_DIV);
  assign sel_tun  = (addr == `OCCR_ADDR_RC_TUNE);
  assign ctrl_wr  = wr && sel_ctrl && (unl_ff == OCCR_UNL_OPEN);   // [R11]
  assign irq_rise = irq_s && !irq_d_ff;

  // ------------------------------------------------------------
  // unlock sequence: key1 then key2 written to control address
  // ------------------------------------------------------------
  // keys opened only for the next access; any other access shuts it
  always_ff @(posedge clk) begin
    if (!por_n) begin
      unl_ff <= OCCR_UNL_IDLE;
    end else if (wr && sel_ctrl) begin
      unique case (unl_ff)
        OCCR_UNL_IDLE: unl_ff <= (wdata == `OCCR_UNLOCK_KEY1) ? OCCR_UNL_KEY1 : OCCR_UNL_IDLE;   // [R11]
        OCCR_UNL_KEY1: unl_ff <= (wdata == `OCCR_UNLOCK_KEY2) ? OCCR_UNL_OPEN : OCCR_UNL_IDLE;   // [R11]
        OCCR_UNL_OPEN: unl_ff <= OCCR_UNL_IDLE;
        default:       unl_ff <= OCCR_UNL_IDLE;
      endcase
    end else if (wr || rd) begin
      unl_ff <= OCCR_UNL_IDLE;
    end
  end

  // ------------------------------------------------------------
  // oscillator control register
  // ------------------------------------------------------------
  // rstn is deliberately unused here: only power-on reset clears these
  always_ff @(posedge clk) begin
    if (!por_n) begin   // [R1]
      cur_ff     <= occr_src_t'(init_source_cfg);   // [R4]
      nxt_src_ff <= occr_src_t'(init_source_cfg);   // [R4]
      lock_ff    <= 1'b0;
      pinlock_ff <= 1'b0;
      sosc_ff    <= 1'b0;   // [R9]
      swreq_ff   <= 1'b0;
      sw_cnt_ff  <= 4'h0;
    end else begin
      if (ctrl_wr) begin
        nxt_src_ff <= occr_src_t'(wdata[`OCCR_NXT_HI:`OCCR_NXT_LO]);   // [R3]
        pinlock_ff <= wdata[`OCCR_PINLOCK_BIT];   // [R6]
        sosc_ff    <= wdata[`OCCR_SOSC_BIT];   // [R9]
        if (switch_monitor_config == 2'h1) begin
          lock_ff <= wdata[`OCCR_LOCK_BIT];   // [R5]
        end
      end
      if (swreq_ff) begin
        if (sw_cnt_ff == `OCCR_SW_CYCLES) begin
          cur_ff    <= nxt_src_ff;   // [R20]
          swreq_ff  <= 1'b0;   // [R10]
          sw_cnt_ff <= 4'h0;
        end else begin
          sw_cnt_ff <= sw_cnt_ff + 4'h1;
        end
      end else if (ctrl_wr && wdata[`OCCR_SWREQ_BIT] && switch_allowed) begin
        swreq_ff <= 1'b1;   // [R10] [R20]
      end
    end
  end

  // ------------------------------------------------------------
  // clock fail flag
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!por_n) begin
      fail_ff <= 1'b0;
    end else if (fail_s && switch_monitor_config == 2'h0) begin
      fail_ff <= 1'b1;   // [R8] [R19] set beats clear
    end else if (ctrl_wr && !wdata[`OCCR_FAIL_BIT]) begin
      fail_ff <= 1'b0;   // [R8]
    end
  end

  // ------------------------------------------------------------
  // clock divisor and tuning registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!por_n) begin   // [R1]
      roi_ff   <= 1'b0;
      doze_ff  <= `OCCR_DOZE_RST;   // [R13]
      ratio_reduction_enable_ff <= 1'b0;
      post_ff  <= `OCCR_POST_RST;   // [R15]
      tun_ff   <= `OCCR_TUN_RST;   // [R16]
      irq_d_ff <= 1'b0;
    end else begin
      irq_d_ff <= irq_s;
      if (wr && sel_div) begin
        roi_ff  <= wdata[`OCCR_ROI_BIT];
        doze_ff <= wdata[`OCCR_DOZE_HI:`OCCR_DOZE_LO];
        post_ff <= wdata[`OCCR_POST_HI:`OCCR_POST_LO];
      end
      if (wr && sel_tun) begin
        tun_ff <= wdata[`OCCR_TUN_HI:`OCCR_TUN_LO];   // [R16]
      end
      if (roi_ff && irq_rise) begin
        ratio_reduction_enable_ff <= 1'b0;   // [R12] interrupt wins over a write
      end else if (wr && sel_div) begin
        ratio_reduction_enable_ff <= wdata[`OCCR_RATIO_REDUCTION_ENABLE_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // instruction clock and doze divider
  // ------------------------------------------------------------
  logic       fcy_ff;
  logic [6:0] doze_cnt_ff;
  logic [6:0] doze_lim;
  assign doze_lim = ratio_reduction_enable_ff ? 7'((8'h01 << doze_ff) - 8'h01) : 7'h00;   // [R13] [R14]
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fcy_ff <= 1'b0;
    end else begin
      fcy_ff <= !fcy_ff;   // [R18]
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      doze_cnt_ff   <= 7'h00;
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
    end else begin
      cpu_clk_en <= fcy_ff;   // [R18]
      periph_clk_en <= 1'b0;
      if (fcy_ff) begin
        if (doze_cnt_ff >= doze_lim) begin
          doze_cnt_ff   <= 7'h00;
          periph_clk_en <= 1'b1;   // [R14]
        end else begin
          doze_cnt_ff <= doze_cnt_ff + 7'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // status and outputs
  // ------------------------------------------------------------
  logic pll_ok;
  assign pll_ok = pll_en_s && (pll_locked_s || pll_timer_s);   // [R7]
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata                <= `OCCR_ZERO16;
      current_source_sel   <= OCCR_SRC_FRC;
      secondary_osc_enable <= 1'b0;
      pin_select_wr_ok     <= 1'b0;
      fail_safe_monitor    <= 1'b0;
      rc_postscaler_sel    <= `OCCR_POST_RST;
      rc_post_ratio_m1     <= 8'h00;
      rc_trim_field        <= `OCCR_TUN_RST;
    end else begin
      current_source_sel   <= cur_ff;   // [R2]
      secondary_osc_enable <= sosc_ff;   // [R9]
      pin_select_wr_ok     <= pin_select_wr && !pinlock_ff;   // [R6]
      fail_safe_monitor    <= (switch_monitor_config == 2'h0);   // [R19]
      rc_postscaler_sel    <= post_ff;
      rc_post_ratio_m1     <= (post_ff == 3'h7) ? 8'hFF : 8'((9'h001 << post_ff) - 9'h001);   // [R15]
      rc_trim_field        <= tun_ff;   // [R16]
      rdata <= `OCCR_ZERO16;   // [R17]
      if (rd) begin
        if (sel_ctrl) begin
          rdata[`OCCR_CUR_HI:`OCCR_CUR_LO] <= cur_ff;   // [R2]
          rdata[`OCCR_NXT_HI:`OCCR_NXT_LO] <= nxt_src_ff;
          rdata[`OCCR_LOCK_BIT]    <= lock_ff;
          rdata[`OCCR_PINLOCK_BIT] <= pinlock_ff;
          rdata[`OCCR_PLL_BIT]     <= pll_ok;   // [R7]
          rdata[`OCCR_FAIL_BIT]    <= fail_ff;
          rdata[`OCCR_SOSC_BIT]    <= sosc_ff;
          rdata[`OCCR_SWREQ_BIT]   <= swreq_ff;
        end else if (sel_div) begin
          rdata[`OCCR_ROI_BIT]               <= roi_ff;
          rdata[`OCCR_DOZE_HI:`OCCR_DOZE_LO] <= doze_ff;
          rdata[`OCCR_RATIO_REDUCTION_ENABLE_BIT]             <= ratio_reduction_enable_ff;
          rdata[`OCCR_POST_HI:`OCCR_POST_LO] <= post_ff;
        end else if (sel_tun) begin
          rdata[`OCCR_TUN_HI:`OCCR_TUN_LO] <= tun_ff;
        end
      end
    end
  end
endmodule : occr_top
`default_nettype wire

//--- test/occr_top_asserts.sv
// port checker for the oscillator control register block
`timescale 1ns/1ps
`default_nettype none
`include "occr_defs.svh"
module occr_top_asserts (
  input wire logic                    clk,
  input wire logic                    rstn,
  input wire logic                    pin_select_wr,
  input wire logic [1:0]              switch_monitor_config,
  input wire logic [`OCCR_ADDR_W-1:0] addr,
  input wire logic                    rd,
  input wire logic [15:0]             rdata,
  input wire logic                    pin_select_wr_ok,
  input wire logic                    fail_safe_monitor,
  input wire logic                    cpu_clk_en,
  input wire logic [2:0]              rc_postscaler_sel,
  input wire logic [7:0]              rc_post_ratio_m1
);
  // ---------
  // properties
  // ---------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_rd_idle;
    !$past(rd) |-> rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero outside read");
  property p_unmapped;
    $past(rd) && $past(addr) == 2'h3 |-> rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl_gaps;
    $past(rd) && $past(addr) == 2'h0 |-> (rdata & 16'h8814) == 16'h0000;
  endproperty
  a_ctrl_gaps: assert property (p_ctrl_gaps) else $error("control gap bits set");
  property p_tun_gaps;
    $past(rd) && $past(addr) == 2'h2 |-> rdata[15:6] == 10'h000;
  endproperty
  a_tun_gaps: assert property (p_tun_gaps) else $error("tuning upper bits set");
  property p_pin_ok;
    pin_select_wr_ok |-> $past(pin_select_wr);
  endproperty
  a_pin_ok: assert property (p_pin_ok) else $error("pin select write without request");
  property p_mon_off;
    $past(switch_monitor_config) != 2'h0 |-> !fail_safe_monitor;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("monitor on outside mode 00");
  property p_cpu;
    cpu_clk_en |=> !cpu_clk_en ##1 cpu_clk_en;
  endproperty
  a_cpu: assert property (p_cpu) else $error("instruction pulse not every second cycle");
  property p_post;
    rc_post_ratio_m1 == ((rc_postscaler_sel == 3'h7) ? 8'hFF : ((8'h01 << rc_postscaler_sel) - 8'h01));
  endproperty
  a_post: assert property (p_post) else $error("postscaler ratio mismatch");
endmodule : occr_top_asserts
bind occr_top occr_top_asserts occr_top_asserts_inst (
  .clk(clk), .rstn(rstn), .pin_select_wr(pin_select_wr), .switch_monitor_config(switch_monitor_config),
  .addr(addr), .rd(rd), .rdata(rdata), .pin_select_wr_ok(pin_select_wr_ok),
  .fail_safe_monitor(fail_safe_monitor), .cpu_clk_en(cpu_clk_en),
  .rc_postscaler_sel(rc_postscaler_sel), .rc_post_ratio_m1(rc_post_ratio_m1)
);
`default_nettype wire

//--- test/test_occr_top.sv
// self-checking bench for the oscillator control register block
`timescale 1ns/1ps
`default_nettype none
module test_occr_top;
  import occr_pkg::*;
  logic        clk, rstn, por_n, pll_locked, pll_timer_done, pll_enabled, fail_detect, irq_event;
  logic        pin_select_wr, wr, rd, sosc_en, psel_ok, mon, cpu_en, per_en;
  logic [2:0]  init_cfg, post_sel;
  logic [1:0]  smc, addr;
  logic [15:0] wdata, rdata, nc, np;
  logic [7:0]  post_m1;
  logic [5:0]  trim;
  occr_src_t   cur_src;
  int          failures, checks, cyc_cnt;
  occr_top occr_top_inst (.clk(clk), .rstn(rstn), .por_n(por_n), .init_source_cfg(init_cfg),
    .switch_monitor_config(smc), .pll_locked(pll_locked), .pll_timer_done(pll_timer_done),
    .pll_enabled(pll_enabled), .fail_detect(fail_detect), .irq_event(irq_event),
    .pin_select_wr(pin_select_wr), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .current_source_sel(cur_src), .secondary_osc_enable(sosc_en), .pin_select_wr_ok(psel_ok),
    .fail_safe_monitor(mon), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
    .rc_postscaler_sel(post_sel), .rc_post_ratio_m1(post_m1), .rc_trim_field(trim));
  // ---------
  // clock, counters, tasks
  // ---------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // whole run is under a thousand cycles
  always @(posedge clk) begin
    nc <= nc + {15'h0000, cpu_en};
    np <= np + {15'h0000, per_en};
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic cmp(input string n, input logic [15:0] e, s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic wrt(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrt
  task automatic rdc(input logic [1:0] a, input logic [15:0] e, m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp("rdata", e, rdata & m);
  endtask : rdc
  task automatic unl(input logic [15:0] d);
    wrt(2'h0, 16'h0057);
    wrt(2'h0, 16'h00AA);
    wrt(2'h0, d);
  endtask : unl
  task automatic cnt(input logic [15:0] e);
    logic [15:0] c0, p0;
    #1;
    c0 = nc;
    p0 = np;
    repeat (64) @(posedge clk);
    #1;
    cmp("cpu_clk_en", 16'h0020, nc - c0);
    cmp("periph_clk_en", e, np - p0);
  endtask : cnt
  // ---------
  // sequence
  // ---------
  initial begin
    {rstn, por_n, pll_locked, pll_timer_done, pll_enabled, fail_detect, irq_event} = 7'h00;
    {pin_select_wr, wr, rd} = 3'h0;
    init_cfg = 3'h5;
    smc = 2'h1;
    addr = 2'h0;
    wdata = 16'h0000;
    nc = 16'h0000;
    np = 16'h0000;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    por_n <= 1'b1;
    rdc(2'h0, 16'h5500, 16'hFFFF);
    rdc(2'h1, 16'h3000, 16'hFFFF);
    rdc(2'h2, 16'h0000, 16'hFFFF);
    rdc(2'h3, 16'h0000, 16'hFFFF);
    wrt(2'h0, 16'h0102);
    rdc(2'h0, 16'h5500, 16'hFFFF);
    unl(16'h010B);
    rdc(2'h0, 16'h5103, 16'hFFFF);
    repeat (12) @(posedge clk);
    rdc(2'h0, 16'h1102, 16'hFFFF);
    cmp("current_source_sel", 16'h0001, {13'h0000, cur_src});
    cmp("secondary_osc_enable", 16'h0001, {15'h0000, sosc_en});
    unl(16'h0280);
    unl(16'h0281);
    repeat (12) @(posedge clk);
    rdc(2'h0, 16'h1080, 16'h7080);
    unl(16'h0200);
    smc <= 2'h2;
    unl(16'h0201);
    repeat (12) @(posedge clk);
    rdc(2'h0, 16'h1000, 16'h7080);
    pin_select_wr <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      unl(i == 0 ? 16'h0040 : 16'h0000);
      repeat (2) @(posedge clk);
      #1;
      cmp("pin_select_wr_ok", 16'(i), {15'h0000, psel_ok});
    end
    smc <= 2'h0;
    fail_detect <= 1'b1;
    repeat (4) @(posedge clk);
    fail_detect <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    cmp("fail_safe_monitor", 16'h0001, {15'h0000, mon});
    rdc(2'h0, 16'h0008, 16'h0008);
    unl(16'h0008);
    rdc(2'h0, 16'h0008, 16'h0008);
    unl(16'h0000);
    rdc(2'h0, 16'h0000, 16'h0008);
    pll_enabled <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      pll_locked <= (i == 0);
      pll_timer_done <= (i == 2);
      repeat (4) @(posedge clk);
      rdc(2'h0, (i == 1) ? 16'h0000 : 16'h0020, 16'h0020);
    end
    wrt(2'h1, 16'hFFFF);
    rdc(2'h1, 16'hFF00, 16'hFFFF);
    wrt(2'h2, 16'hFFFF);
    rdc(2'h2, 16'h003F, 16'hFFFF);
    cmp("rc_trim_field", 16'h003F, {10'h000, trim});
    for (int s = 0; s < 8; s++) begin
      wrt(2'h1, {5'h00, 3'(s), 8'h00});
      repeat (2) @(posedge clk);
      #1;
      cmp("rc_postscaler_sel", 16'(s), {13'h0000, post_sel});
      cmp("rc_post_ratio_m1", (s == 7) ? 16'h00FF : (16'h0001 << s) - 16'h0001, {8'h00, post_m1});
    end
    wrt(2'h1, 16'h2800);
    cnt(16'h0008);
    wrt(2'h1, 16'h2000);
    cnt(16'h0020);
    for (int i = 0; i < 2; i++) begin
      wrt(2'h1, i == 0 ? 16'hA800 : 16'h2800);
      irq_event <= 1'b1;
      repeat (4) @(posedge clk);
      irq_event <= 1'b0;
      rdc(2'h1, i == 0 ? 16'hA000 : 16'h2800, 16'hFFFF);
    end
    wrt(2'h2, 16'h0015);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rdc(2'h2, 16'h0015, 16'hFFFF);
    init_cfg <= 3'h2;
    rstn <= 1'b0;
    por_n <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    por_n <= 1'b1;
    rdc(2'h2, 16'h0000, 16'hFFFF);
    rdc(2'h0, 16'h2200, 16'hFFDF);
    complete_run();
  end
endmodule : test_occr_top
`default_nettype wire
